/* File: rtl/usc_status_control.sv */
// Serial port with its status and control register, reached over Wishbone.
// Assumes the serial input is already synchronous to clk_i and that the
// pin multiplexer hands the pins to the port when the claim outputs are high.
`timescale 1ns/1ps
`include "usc_map.svh"

// Functional notes
// - With auto address detect on, match received address against 8-bit field.
// - TX level select: 10 buffer empty, 01 all sent, 00 space free.
// - Plain signalling: invert bit makes transmit line idle low, else high.
// - Infrared signalling: invert bit makes encoded output idle high, else low.
// - Receiver enable with module on claims receive pin; otherwise pin ignored.
// - Send break: start, twelve zeros, stop; hardware clears bit afterwards.
// - Clearing transmit enable aborts sending, empties buffer, releases pin.
// - Buffer-full flag reads 1 when transmit buffer full, else 0.
// - Transmitter-empty flag reads 1 only when shifter and buffer empty.
// - RX level select: 10 six or more, 01 four or more, 00 one.
// - Nine-bit mode address detect treats bit 8 set as address characters.
// - Receiver idle flag reads 1 while idle, 0 while receiving.
// - Parity error flag reports parity error of current received character.
// - Framing error flag reports framing error of current received character.
// - Overflow sets overrun; software clear empties receive buffer and shifter.
// - Data-available flag reads 1 when receive buffer holds a character.
// - Parity/data select: nine bits, or eight bits odd, even, none.
// - Infrared enable switches both paths to infrared-encoded signalling.
module usc_status_control #(
	parameter int RX_DEPTH = 8,
	parameter int TX_DEPTH = 4
) (
	input  wire logic        clk_i,          // 20 MHz clock
	input  wire logic        rst_i,          // synchronous reset
	input  wire logic        wb_cyc_i,       // bus cycle
	input  wire logic        wb_stb_i,       // bus strobe
	input  wire logic        wb_we_i,        // write enable
	input  wire logic [4:0]  wb_adr_i,       // byte address
	input  wire logic [3:0]  wb_sel_i,       // byte lanes
	input  wire logic [31:0] wb_dat_i,       // write data
	output logic      [31:0] wb_dat_o,       // read data
	output logic             wb_ack_o,       // acknowledge
	input  wire logic        serial_rx_pin_i,// receive line
	output logic             serial_tx_pin_o,// transmit line
	output logic             serial_tx_oe_o, // transmit pin claimed
	output logic             rx_claim_o,     // receive pin claimed
	output logic             tx_irq_o,       // transmit level flag
	output logic             rx_irq_o        // receive level flag
);
	localparam int RCW = $clog2(RX_DEPTH + 1);

	// Control fields of the status, mode and baud registers, and the bus reply state.
	logic        auto_addr_detect_enable_reg;
	logic [7:0]  match_addr_reg;
	logic [1:0]  tx_irq_select_reg;
	logic        tx_polarity_invert_reg;
	logic        rx_enable_reg;
	logic        tx_send_break_reg;
	logic        tx_enable_reg;
	logic [1:0]  rx_irq_select_reg;
	logic        ninth_bit_addr_detect_reg;
	logic        overrun_error_flag_reg;
	logic        module_on_reg;
	logic        infrared_codec_enable_reg;
	logic [1:0]  parity_data_select_reg;
	logic [15:0] baud_div_reg;
	logic        wb_ack_reg;
	logic [31:0] wb_dat_reg;

	logic        acc;
	logic        wr_acc;
	logic [2:0]  idx;
	logic [31:0] status_rd;
	logic [31:0] rd_next;
	logic        nine_bit;
	logic        long_frame;

	assign acc        = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
	assign wr_acc     = acc & wb_we_i;
	assign idx        = wb_adr_i[4:2];
	assign nine_bit   = (parity_data_select_reg == usc_pkg::USC_PD_9N);
	assign long_frame = (parity_data_select_reg != usc_pkg::USC_PD_8N);

	// Parity bit that makes the character even or odd as selected.
	function automatic logic par_bit(input logic [7:0] d, input logic odd);
		par_bit = (^d) ^ odd;
	endfunction

	// Baud tick at sixteen times the bit rate.
	logic [15:0] baud_cnt_reg;
	logic        tick;
	assign tick = (baud_cnt_reg == 16'h0000);
	always_ff @(posedge clk_i) begin
		if (rst_i || !module_on_reg)
			baud_cnt_reg <= 16'h0000;
		else
			baud_cnt_reg <= tick ? baud_div_reg : 16'(baud_cnt_reg - 1'b1);
	end

	// Transmit path.
	logic                 tx_active;
	logic                 tx_push;
	logic                 tx_wr_ready;
	logic                 tx_rd_valid;
	logic                 tx_pop;
	logic [8:0]           tx_head;
	usc_pkg::usc_tx_state_t tx_state_reg;
	logic [13:0]          tx_frame_reg;
	logic [3:0]           tx_bits_reg;
	logic [3:0]           tx_phase_reg;
	logic                 tx_is_break_reg;
	logic                 tx_bit;
	logic                 tx_ir_bit;
	logic                 tx_all_empty;
	logic                 tx_done;
	logic                 tx_start_brk;

	assign tx_active = module_on_reg & tx_enable_reg;
	assign tx_push   = wr_acc && idx == `USC_IDX_TXDATA && wb_sel_i[0];
	assign tx_start_brk = tx_active && tx_state_reg == usc_pkg::USC_TX_IDLE
		&& tx_send_break_reg;
	assign tx_pop = tx_active && tx_state_reg == usc_pkg::USC_TX_IDLE
		&& !tx_send_break_reg && tx_rd_valid;
	assign tx_done = tick && tx_state_reg == usc_pkg::USC_TX_SHIFT
		&& tx_phase_reg == `USC_TICK_LAST && tx_bits_reg == 4'h1;
	assign tx_all_empty = tx_state_reg == usc_pkg::USC_TX_IDLE
		&& !tx_rd_valid;

	usc_char_fifo #(.WIDTH(9), .DEPTH(TX_DEPTH)) u_tx_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.flush_i    (!tx_enable_reg),
		.wr_valid_i (tx_push),
		.wr_ready_o (tx_wr_ready),
		.wr_data_i  (wb_dat_i[8:0]),
		.rd_valid_o (tx_rd_valid),
		.rd_ready_i (tx_pop),
		.rd_data_o  (tx_head),
		.count_o    ()
	);

	always_ff @(posedge clk_i) begin
		if (rst_i || !tx_active) begin
			tx_state_reg    <= usc_pkg::USC_TX_IDLE;
			tx_frame_reg    <= 14'h3FFF;
			tx_bits_reg     <= 4'h0;
			tx_phase_reg    <= 4'h0;
			tx_is_break_reg <= 1'b0;
		end else if (tx_start_brk) begin
			tx_state_reg    <= usc_pkg::USC_TX_SHIFT;
			tx_frame_reg    <= {1'b1, 12'h000, 1'b0};
			tx_bits_reg     <= `USC_BITS_BREAK;
			tx_phase_reg    <= 4'h0;
			tx_is_break_reg <= 1'b1;
		end else if (tx_pop) begin
			tx_state_reg    <= usc_pkg::USC_TX_SHIFT;
			tx_phase_reg    <= 4'h0;
			tx_is_break_reg <= 1'b0;
			if (long_frame) begin
				tx_bits_reg  <= `USC_BITS_LONG;
				tx_frame_reg <= {3'h7, 1'b1, nine_bit ? tx_head[8] :
					par_bit(tx_head[7:0], parity_data_select_reg[1]),
					tx_head[7:0], 1'b0};
			end else begin
				tx_bits_reg  <= `USC_BITS_SHORT;
				tx_frame_reg <= {4'hF, 1'b1, tx_head[7:0], 1'b0};
			end
		end else if (tick && tx_state_reg == usc_pkg::USC_TX_SHIFT) begin
			tx_phase_reg <= 4'(tx_phase_reg + 1'b1);
			if (tx_phase_reg == `USC_TICK_LAST) begin
				tx_frame_reg <= {1'b1, tx_frame_reg[13:1]};
				tx_bits_reg  <= 4'(tx_bits_reg - 1'b1);
				if (tx_bits_reg == 4'h1)
					tx_state_reg <= usc_pkg::USC_TX_IDLE;
			end
		end
	end

	// Infrared pulses mark zero bits for the first three ticks of a bit.
	assign tx_bit    = tx_state_reg == usc_pkg::USC_TX_SHIFT ?
		tx_frame_reg[0] : 1'b1;
	assign tx_ir_bit = tx_state_reg == usc_pkg::USC_TX_SHIFT && !tx_bit
		&& tx_phase_reg < `USC_IR_PULSE;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_tx_pin_o <= 1'b1;
			serial_tx_oe_o  <= 1'b0;
		end else begin
			serial_tx_oe_o <= tx_active;
			if (infrared_codec_enable_reg)
				serial_tx_pin_o <= tx_ir_bit ^ tx_polarity_invert_reg;
			else
				serial_tx_pin_o <= tx_bit ^ tx_polarity_invert_reg;
		end
	end

	// Receive path.
	logic                 rx_active;
	logic                 rx_level;
	logic                 rx_sample;
	logic                 ir_seen_reg;
	usc_pkg::usc_rx_state_t rx_state_reg;
	logic [10:0]          rx_shift_register;
	logic [3:0]           rx_bits_reg;
	logic [3:0]           rx_phase_reg;
	logic                 addr_matched_reg;
	logic                 rx_mid;
	logic                 rx_done;
	logic [7:0]           rx_data;
	logic                 rx_ninth;
	logic                 rx_parity_error_flag;
	logic                 rx_framing_error_flag;
	logic                 rx_is_addr;
	logic                 rx_accept;
	logic                 rx_push;
	logic                 rx_wr_ready;
	logic                 rx_rd_valid;
	logic                 rx_pop;
	logic [10:0]          rx_head;
	logic [RCW-1:0]       rx_count;
	logic                 overrun_error_flag_set;
	logic                 overrun_error_flag_sw_clear;

	assign rx_active = module_on_reg & rx_enable_reg;
	assign rx_level  = infrared_codec_enable_reg ?
		~serial_rx_pin_i : serial_rx_pin_i;
	assign rx_sample = infrared_codec_enable_reg ?
		~ir_seen_reg : serial_rx_pin_i;
	assign rx_mid    = tick && rx_state_reg == usc_pkg::USC_RX_RECV
		&& rx_phase_reg == `USC_TICK_MID;
	assign rx_done   = rx_mid && rx_bits_reg == 4'h1;
	assign overrun_error_flag_sw_clear = wr_acc && idx == `USC_IDX_STATUS && wb_sel_i[0]
		&& !wb_dat_i[`USC_STA_OVERRUN_ERROR_FLAG] && overrun_error_flag_reg;

	// The sampled stop bit is not yet in the shifter when rx_done is high.
	assign rx_data  = long_frame ? rx_shift_register[9:2] :
		rx_shift_register[10:3];
	assign rx_ninth = rx_shift_register[10];
	assign rx_parity_error_flag  = long_frame && !nine_bit &&
		(rx_ninth != par_bit(rx_data, parity_data_select_reg[1]));
	assign rx_framing_error_flag  = !rx_sample;
	assign rx_is_addr = nine_bit && rx_ninth;
	always_comb begin
		rx_accept = 1'b1;
		if (nine_bit && ninth_bit_addr_detect_reg) begin
			if (auto_addr_detect_enable_reg)
				rx_accept = rx_is_addr ? (rx_data == match_addr_reg)
					: addr_matched_reg;
			else
				rx_accept = rx_is_addr;
		end
	end
	assign rx_push  = rx_done && rx_accept && !overrun_error_flag_reg;
	assign overrun_error_flag_set = rx_push && !rx_wr_ready;
	assign rx_pop   = acc && !wb_we_i && idx == `USC_IDX_RXDATA;

	usc_char_fifo #(.WIDTH(11), .DEPTH(RX_DEPTH)) u_rx_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.flush_i    (overrun_error_flag_sw_clear),
		.wr_valid_i (rx_push),
		.wr_ready_o (rx_wr_ready),
		.wr_data_i  ({rx_parity_error_flag, rx_framing_error_flag, rx_ninth & nine_bit, rx_data}),
		.rd_valid_o (rx_rd_valid),
		.rd_ready_i (rx_pop),
		.rd_data_o  (rx_head),
		.count_o    (rx_count)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i || rx_mid)
			ir_seen_reg <= 1'b0;
		else if (serial_rx_pin_i)
			ir_seen_reg <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_active || overrun_error_flag_sw_clear) begin
			rx_state_reg      <= usc_pkg::USC_RX_IDLE;
			rx_shift_register <= 11'h000;
			rx_bits_reg       <= 4'h0;
			rx_phase_reg      <= 4'h0;
		end else if (rx_state_reg == usc_pkg::USC_RX_IDLE) begin
			if (!rx_level) begin
				rx_state_reg <= usc_pkg::USC_RX_RECV;
				rx_phase_reg <= 4'h0;
				rx_bits_reg  <= long_frame ? `USC_BITS_LONG : `USC_BITS_SHORT;
			end
		end else if (tick) begin
			rx_phase_reg <= 4'(rx_phase_reg + 1'b1);
			if (rx_mid) begin
				rx_shift_register <= {rx_sample, rx_shift_register[10:1]};
				rx_bits_reg       <= 4'(rx_bits_reg - 1'b1);
				// A start bit that has gone high by mid-bit was a glitch.
				if (rx_bits_reg == 4'h1 ||
				    (rx_sample && rx_bits_reg ==
				     (long_frame ? `USC_BITS_LONG : `USC_BITS_SHORT)))
					rx_state_reg <= usc_pkg::USC_RX_IDLE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_active)
			addr_matched_reg <= 1'b0;
		else if (rx_done && rx_is_addr)
			addr_matched_reg <= (rx_data == match_addr_reg);
	end

	// Register file.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_addr_detect_enable_reg <= 1'b0;
			match_addr_reg              <= 8'h00;
			tx_irq_select_reg           <= 2'h0;
			tx_polarity_invert_reg      <= 1'b0;
			rx_enable_reg               <= 1'b0;
			tx_enable_reg               <= 1'b0;
			rx_irq_select_reg           <= 2'h0;
			ninth_bit_addr_detect_reg   <= 1'b0;
			module_on_reg               <= 1'b0;
			infrared_codec_enable_reg   <= 1'b0;
			parity_data_select_reg      <= 2'h0;
			baud_div_reg                <= `USC_BAUD_RESET;
		end else if (wr_acc && idx == `USC_IDX_STATUS) begin
			if (wb_sel_i[3])
				auto_addr_detect_enable_reg <= wb_dat_i[`USC_STA_ADM];
			if (wb_sel_i[2])
				match_addr_reg <= wb_dat_i[`USC_STA_ADDR +: 8];
			if (wb_sel_i[1]) begin
				tx_irq_select_reg      <= wb_dat_i[`USC_STA_TXISEL +: 2];
				tx_polarity_invert_reg <= wb_dat_i[`USC_STA_TXINV];
				rx_enable_reg          <= wb_dat_i[`USC_STA_RXEN];
				tx_enable_reg          <= wb_dat_i[`USC_STA_TXEN];
			end
			if (wb_sel_i[0]) begin
				rx_irq_select_reg         <= wb_dat_i[`USC_STA_RXISEL +: 2];
				ninth_bit_addr_detect_reg <= wb_dat_i[`USC_STA_NINTH_BIT_ADDR_DETECT];
			end
		end else if (wr_acc && idx == `USC_IDX_MODE) begin
			if (wb_sel_i[1]) begin
				module_on_reg             <= wb_dat_i[`USC_MODE_ON];
				infrared_codec_enable_reg <= wb_dat_i[`USC_MODE_INFRARED_CODEC_ENABLE];
			end
			if (wb_sel_i[0])
				parity_data_select_reg <= wb_dat_i[`USC_MODE_PARITY_DATA_SELECT +: 2];
		end else if (wr_acc && idx == `USC_IDX_BAUD) begin
			if (wb_sel_i[1])
				baud_div_reg[15:8] <= wb_dat_i[15:8];
			if (wb_sel_i[0])
				baud_div_reg[7:0] <= wb_dat_i[7:0];
		end
	end

	// Software sets the break request; completion clears it.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			tx_send_break_reg <= 1'b0;
		else if (wr_acc && idx == `USC_IDX_STATUS && wb_sel_i[1])
			tx_send_break_reg <= wb_dat_i[`USC_STA_BRK];
		else if (tx_done && tx_is_break_reg)
			tx_send_break_reg <= 1'b0;
	end

	// The overflow event wins over a software clear in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			overrun_error_flag_reg <= 1'b0;
		else if (overrun_error_flag_set)
			overrun_error_flag_reg <= 1'b1;
		else if (overrun_error_flag_sw_clear)
			overrun_error_flag_reg <= 1'b0;
	end

	always_comb begin
		status_rd = 32'h0000_0000;
		status_rd[`USC_STA_ADM]       = auto_addr_detect_enable_reg;
		status_rd[`USC_STA_ADDR +: 8] = match_addr_reg;
		status_rd[`USC_STA_TXISEL +: 2] = tx_irq_select_reg;
		status_rd[`USC_STA_TXINV]     = tx_polarity_invert_reg;
		status_rd[`USC_STA_RXEN]      = rx_enable_reg;
		status_rd[`USC_STA_BRK]       = tx_send_break_reg;
		status_rd[`USC_STA_TXEN]      = tx_enable_reg;
		status_rd[`USC_STA_TXBF]      = !tx_wr_ready;
		status_rd[`USC_STA_TX_ALL_EMPTY]      = tx_all_empty;
		status_rd[`USC_STA_RXISEL +: 2] = rx_irq_select_reg;
		status_rd[`USC_STA_NINTH_BIT_ADDR_DETECT]     = ninth_bit_addr_detect_reg;
		status_rd[`USC_STA_RX_IDLE_FLAG]     =
			(rx_state_reg == usc_pkg::USC_RX_IDLE);
		status_rd[`USC_STA_PARITY_ERROR_FLAG]      = rx_rd_valid & rx_head[10];
		status_rd[`USC_STA_FRAMING_ERROR_FLAG]      = rx_rd_valid & rx_head[9];
		status_rd[`USC_STA_OVERRUN_ERROR_FLAG]      = overrun_error_flag_reg;
		status_rd[`USC_STA_RXDA]      = rx_rd_valid;
	end

	always_comb begin
		case (idx)
			`USC_IDX_STATUS: rd_next = status_rd;
			`USC_IDX_MODE:   rd_next = {16'h0000, module_on_reg, 2'h0,
				infrared_codec_enable_reg, 9'h000,
				parity_data_select_reg, 1'b0};
			`USC_IDX_BAUD:   rd_next = {16'h0000, baud_div_reg};
			`USC_IDX_RXDATA: rd_next = {23'h000000, rx_head[8:0]};
			default:         rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h0000_0000;
		end else begin
			wb_ack_reg <= acc;
			if (acc && !wb_we_i)
				wb_dat_reg <= rd_next;
		end
	end
	assign wb_ack_o = wb_ack_reg;
	assign wb_dat_o = wb_dat_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_claim_o <= 1'b0;
			tx_irq_o   <= 1'b0;
			rx_irq_o   <= 1'b0;
		end else begin
			rx_claim_o <= rx_active;
			case (tx_irq_select_reg)
				2'h2:    tx_irq_o <= !tx_rd_valid;
				2'h1:    tx_irq_o <= tx_all_empty;
				2'h0:    tx_irq_o <= tx_wr_ready;
				default: tx_irq_o <= 1'b0;
			endcase
			case (rx_irq_select_reg)
				2'h2:    rx_irq_o <= rx_count >= RCW'(`USC_RX_LVL_HIGH);
				2'h1:    rx_irq_o <= rx_count >= RCW'(`USC_RX_LVL_HALF);
				2'h0:    rx_irq_o <= rx_count >= RCW'(`USC_RX_LVL_ONE);
				default: rx_irq_o <= 1'b0;
			endcase
		end
	end
endmodule // usc_status_control

/* File: rtl/usc_map.svh */
// Register indices, field positions, reset values and timing counts of the
// serial port status and control block.
// Assumes a 32-bit Wishbone slave decoding word indices from adr[4:2].
`ifndef USC_MAP_SVH
`define USC_MAP_SVH

`define USC_IDX_STATUS   3'h0
`define USC_IDX_MODE     3'h1
`define USC_IDX_BAUD     3'h2
`define USC_IDX_TXDATA   3'h3
`define USC_IDX_RXDATA   3'h4

`define USC_STA_ADM      24
`define USC_STA_ADDR     16
`define USC_STA_TXISEL   14
`define USC_STA_TXINV    13
`define USC_STA_RXEN     12
`define USC_STA_BRK      11
`define USC_STA_TXEN     10
`define USC_STA_TXBF     9
`define USC_STA_TX_ALL_EMPTY     8
`define USC_STA_RXISEL   6
`define USC_STA_NINTH_BIT_ADDR_DETECT    5
`define USC_STA_RX_IDLE_FLAG    4
`define USC_STA_PARITY_ERROR_FLAG     3
`define USC_STA_FRAMING_ERROR_FLAG     2
`define USC_STA_OVERRUN_ERROR_FLAG     1
`define USC_STA_RXDA     0

`define USC_MODE_ON      15
`define USC_MODE_INFRARED_CODEC_ENABLE    12
`define USC_MODE_PARITY_DATA_SELECT   1

`define USC_BAUD_RESET   16'h0009
`define USC_TICK_LAST    4'hF
`define USC_TICK_MID     4'h7
`define USC_IR_PULSE     4'h3
`define USC_BITS_BREAK   4'hE
`define USC_BITS_LONG    4'hB
`define USC_BITS_SHORT   4'hA
`define USC_RX_LVL_HIGH  4'h6
`define USC_RX_LVL_HALF  4'h4
`define USC_RX_LVL_ONE   4'h1

`endif

/* File: rtl/usc_pkg.sv */
// Types shared by the serial port status and control block.
// Assumes nothing beyond a SystemVerilog compiler.
package usc_pkg;
	typedef enum logic [1:0] {
		USC_PD_8N = 2'h0,
		USC_PD_8E = 2'h1,
		USC_PD_8O = 2'h2,
		USC_PD_9N = 2'h3
	} usc_parity_data_select_t;
	typedef enum logic {USC_TX_IDLE, USC_TX_SHIFT} usc_tx_state_t;
	typedef enum logic {USC_RX_IDLE, USC_RX_RECV} usc_rx_state_t;
endpackage

/* File: rtl/usc_char_fifo.sv */
// Character FIFO in flip-flops with valid/ready on both sides and a flush.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module usc_char_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             clk_i,      // clock
	input  wire logic             rst_i,      // synchronous reset
	input  wire logic             flush_i,    // empty the FIFO
	input  wire logic             wr_valid_i, // push request
	output logic                  wr_ready_o, // space available
	input  wire logic [WIDTH-1:0] wr_data_i,  // push data
	output logic                  rd_valid_o, // data available
	input  wire logic             rd_ready_i, // pop request
	output logic      [WIDTH-1:0] rd_data_o,  // head data
	output logic      [CW-1:0]    count_o     // fill level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign wr_ready_o = (count_reg != CW'(DEPTH));
	assign rd_valid_o = (count_reg != '0);
	assign rd_data_o  = mem_reg[rd_ptr_reg];
	assign count_o    = count_reg;
	assign push       = wr_valid_i & wr_ready_o;
	assign pop        = rd_ready_i & rd_valid_o;

	always_ff @(posedge clk_i) begin
		if (push)
			mem_reg[wr_ptr_reg] <= wr_data_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			if (push && !pop)
				count_reg <= CW'(count_reg + 1'b1);
			else if (pop && !push)
				count_reg <= CW'(count_reg - 1'b1);
		end
	end
endmodule // usc_char_fifo

/* File: sim/usc_chk.sv */
// Port assertions for the serial port status and control block.
// Assumes a bind from the bench top and a synchronous active-high reset.
`timescale 1ns/1ps
module usc_chk (
	input wire logic        clk_i,           // clock
	input wire logic        rst_i,           // reset
	input wire logic        wb_cyc_i,        // bus cycle
	input wire logic        wb_stb_i,        // bus strobe
	input wire logic        wb_we_i,         // write enable
	input wire logic [31:0] wb_dat_o,        // read data
	input wire logic        wb_ack_o,        // acknowledge
	input wire logic        serial_tx_pin_o, // transmit line
	input wire logic        serial_tx_oe_o,  // transmit claim
	input wire logic        rx_claim_o,      // receive claim
	input wire logic        tx_irq_o,        // transmit level
	input wire logic        rx_irq_o         // receive level
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Register writes land one edge before the outputs that follow them.
	sequence s_bus_touch;
		wb_ack_o || $past(wb_ack_o);
	endsequence
	AST_ACK_ANSWER: assert property (s_take |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_QUIET: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
		else $error("read data moved outside a read");
	AST_RESET_STATE: assert property ($fell(rst_i) |-> !wb_ack_o &&
		!serial_tx_oe_o && !rx_claim_o && serial_tx_pin_o && !tx_irq_o &&
		!rx_irq_o && wb_dat_o == 32'h0) else $error("bad reset outputs");
	AST_TXIRQ_WAKE: assert property ($fell(rst_i) |=> tx_irq_o)
		else $error("transmit level low with free space");
	AST_CLAIM_BY_WRITE: assert property (($changed(serial_tx_oe_o) ||
		$changed(rx_claim_o)) |-> s_bus_touch) else $error("claim moved alone");
	AST_PIN_PARKED: assert property (!serial_tx_oe_o &&
		$changed(serial_tx_pin_o) |-> s_bus_touch) else $error("released pin moved");
endmodule // usc_chk

/* File: sim/usc_far_end.sv */
// Remote serial device: sends frames on the receive line, samples transmit.
// Assumes 16 clocks per bit, the block's baud divisor being 0.
`timescale 1ns/1ps
module usc_far_end #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic clk_i,     // bench clock
	input  wire logic tx_line_i, // block transmit line
	output logic      rx_line_o  // block receive line
);
	initial rx_line_o = 1'b1;
	// Start bit, then n bits LSB first; the caller supplies stop or faults.
	task automatic send(input logic [10:0] b, input int n);
		@(posedge clk_i);
		rx_line_o <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rx_line_o <= b[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		rx_line_o <= 1'b1;
	endtask
	task automatic grab(output logic [13:0] bits);
		@(negedge tx_line_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 14; i++) begin
			bits[i] = tx_line_i;
			repeat (BIT_CLKS) @(posedge clk_i);
		end
	endtask
endmodule // usc_far_end

/* File: sim/usc_status_control_tb.sv */
// Self-checking bench for the serial port status and control block.
// Assumes the checker and far-end model files are compiled before it.
`timescale 1ns/1ps
module usc_status_control_tb;
	localparam logic [4:0]  A_ST = 5'h00, A_MD = 5'h04, A_RX = 5'h10;
	localparam logic [31:0] EN = 32'h0000_1400, ON = 32'h0000_8000;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        rx_pin, tx_pin, tx_oe, rx_claim, tx_irq, rx_irq;
	logic [4:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [13:0] fr;
	logic [8:0]  d;
	int          fails, compares;
	usc_status_control usc_status_control_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_rx_pin_i(rx_pin),
		.serial_tx_pin_o(tx_pin), .serial_tx_oe_o(tx_oe),
		.rx_claim_o(rx_claim), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
	usc_far_end usc_far_end_i (.clk_i(clk_i), .tx_line_i(tx_pin),
		.rx_line_o(rx_pin));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Called just after an edge; holds the request until ack is sampled.
	task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] w);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= w;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_sel_i <= 4'h0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e, m,
		input string n);
		wb(1'b0, a, 32'h0);
		chk(n, e, rd & m);
	endtask
	function automatic logic rxlvl(input int s, n);
		return s == 2 ? n >= 6 : s == 1 ? n >= 4 : s == 0 ? n >= 1 : 1'b0;
	endfunction
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		stop_test();
	end
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		{wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{fails, compares} = '0;
		void'($urandom(32'h530D));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc(A_ST, 32'h0000_0110, 32'hFFFF_FFFF, "reset");
		rdc(5'h1C, 32'h0, 32'hFFFF_FFFF, "unmapped");
		wb(1'b1, 5'h08, 32'h0);
		wb(1'b1, A_MD, ON);
		wb(1'b1, A_ST, EN);
		chk("claims", 32'h3, {tx_oe, rx_claim});
		repeat (3) begin
			d = 9'($urandom) & 9'h0FF;
			fork
				usc_far_end_i.grab(fr);
				wb(1'b1, 5'h0C, {23'h0, d});
			join
			chk("tx frame", {4'hF, 1'b1, d[7:0], 1'b0}, fr);
		end
		repeat (6) wb(1'b1, 5'h0C, 32'h0000_0055);
		rdc(A_ST, 32'h0000_0200, 32'h0000_0300, "full");
		chk("tx irq full", 32'h0, tx_irq);
		for (int s = 1; s < 3; s++) begin
			wb(1'b1, A_ST, EN | (s << 14));
			chk("tx irq busy", 32'h0, tx_irq);
		end
		wb(1'b1, A_ST, 32'h0000_1000);
		rdc(A_ST, 32'h0000_0100, 32'h0000_0300, "flushed");
		chk("tx released", 32'h0, tx_oe);
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, A_ST, 32'h0000_1000 | (s << 14));
			chk("tx irq", s != 3, tx_irq);
		end
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, A_MD, ON | (k[1] << 12));
			// Receiver off: an idle-high line reads as pulses in infrared form.
			wb(1'b1, A_ST, 32'h0000_0400 | (k[0] << 13));
			chk("idle level", k[0] == k[1], tx_pin);
		end
		wb(1'b1, A_MD, ON);
		fork
			usc_far_end_i.grab(fr);
			wb(1'b1, A_ST, EN | 32'h0000_0800);
		join
		chk("break", 32'h2000, fr);
		rdc(A_ST, 32'h0, 32'h0000_0800, "break clear");
		for (int n = 1; n <= 9; n++) begin
			usc_far_end_i.send({3'b001, 8'($urandom)}, 9);
			for (int s = 0; s < 4 && n < 9; s++) begin
				wb(1'b1, A_ST, EN | (s << 6));
				chk("rx irq", rxlvl(s, n), rx_irq);
			end
		end
		rdc(A_ST, 32'h3, 32'h3, "overrun");
		wb(1'b1, A_ST, EN);
		rdc(A_ST, 32'h0, 32'h3, "overrun clear");
		d = 9'($urandom) & 9'h0FF;
		fork
			usc_far_end_i.send({3'b001, d[7:0]}, 9);
			begin
				repeat (40) @(posedge clk_i);
				rdc(A_ST, 32'h0, 32'h10, "rx busy");
			end
		join
		rdc(A_ST, 32'h11, 32'h11, "rx done");
		rdc(A_RX, d, 32'h1FF, "rx data");
		wb(1'b1, A_MD, ON | 32'h2);
		usc_far_end_i.send({2'b01, ~^d[7:0], d[7:0]}, 10);
		rdc(A_ST, 32'h9, 32'h9, "parity");
		wb(1'b0, A_RX, 32'h0);
		wb(1'b1, A_MD, ON | 32'h6);
		wb(1'b1, A_ST, EN | 32'h0100_0020 | (d[7:0] << 16));
		usc_far_end_i.send({2'b01, 1'b1, ~d[7:0]}, 10);
		usc_far_end_i.send({2'b01, 1'b0, d[7:0]}, 10);
		usc_far_end_i.send({2'b01, 1'b1, d[7:0]}, 10);
		usc_far_end_i.send({2'b01, 1'b0, ~d[7:0]}, 10);
		rdc(A_RX, {1'b1, d[7:0]}, 32'h1FF, "addr char");
		rdc(A_RX, {1'b0, ~d[7:0]}, 32'h1FF, "data char");
		rdc(A_ST, 32'h0, 32'h1, "filtered");
		// A low stop may look like a new start, so this case runs last.
		wb(1'b1, A_MD, ON);
		usc_far_end_i.send({3'b000, d[7:0]}, 9);
		rdc(A_ST, 32'h5, 32'hD, "framing");
		stop_test();
	end
endmodule // usc_status_control_tb
bind usc_status_control usc_chk usc_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.serial_tx_pin_o(serial_tx_pin_o), .serial_tx_oe_o(serial_tx_oe_o),
	.rx_claim_o(rx_claim_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
